/* File: design/aifl_pkg.sv */
// Operation
// - end-limit stops set error bits 0, 1
// - alarm stop or alarm-while-stopped sets bit 2
// - simultaneous-stop line stop sets bit 3
// - emergency input or command 05h sets bit 4
// - slow-down stop sets error bit 5
// - pulser buffer overflow stop sets bit 6
// - encoder error bit 7, pulser error bit 8
// - software-limit stops set bits 9, 10
// - normal stop and prereg free: bits 0, 1
// - accel/decel phases map to bits 2..5
// - comparator matches set status bits 6, 7
// - latch, origin, slow-down set bits 8..10
// - switch changes bits 11, 12, enable 11
// - start line low: status 13, enable 12
// - soft-limit events bits 14, 15, ungated
// - origin-decel stop option stop sets bit 16
// - motion start: status 17, enable 14
// - latch three/four: status 18, 19
// - errors always interrupt; events only enabled, bar 14, 15
// - interrupt holds until all factors cleared
// - manual mode: write-one clears via B2h/B3h
// - F2h copies errors; auto mode clears
package aifl_pkg;
  localparam int unsigned ERR_W = 11;
  localparam int unsigned EVT_W = 20;
  localparam int unsigned EN_W = 18;
  localparam int unsigned BUF_W = 32;
  localparam logic [7:0] CMD_EMERGENCY = 8'h05;
  localparam logic [7:0] CMD_WR_MASK = 8'hac;
  localparam logic [7:0] CMD_CLR_ERR = 8'hb2;
  localparam logic [7:0] CMD_CLR_EVT = 8'hb3;
  localparam logic [7:0] CMD_RD_ERR = 8'hf2;
  localparam logic [7:0] CMD_RD_EVT = 8'hf3;
  localparam int unsigned ERR_EMERGENCY = 4;
  localparam logic [EN_W-1:0] EN_RESET = 18'h00000;
  // status bit -> enable bit position; soft limits have none
  localparam int unsigned NO_EN = 31;
  function automatic int unsigned aifl_en_pos(input int unsigned st);
    if (st <= 10) begin
      return st;
    end else if (st <= 12) begin
      return 11;
    end else if (st == 13) begin
      return 12;
    end else if (st <= 15) begin
      return NO_EN;
    end else if (st == 16) begin
      return 13;
    end else if (st == 17) begin
      return 14;
    end else begin
      return st - 2;
    end
  endfunction
endpackage

/* File: design/aifl_sync.sv */
`timescale 1ns/10ps
module aifl_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule

/* File: design/aifl_top.sv */
`timescale 1ns/10ps
module aifl_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // host command port, same clock domain
  input wire logic cmd_we_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [31:0] buf_wdata_i,
  input wire logic manual_clear_i,
  output logic [31:0] buf_rdata_o,
  output logic buf_rvalid_o,
  // cause pulses from the axis logic, same clock domain
  input wire logic stop_pos_end_i,
  input wire logic stop_neg_end_i,
  input wire logic stop_alarm_i,
  input wire logic stop_simul_i,
  input wire logic stop_slowdown_i,
  input wire logic stop_pulser_ovf_i,
  input wire logic stop_pos_soft_i,
  input wire logic stop_neg_soft_i,
  input wire logic stop_normal_i,
  input wire logic stop_in_decel_i,
  input wire logic axis_stopped_i,
  input wire logic encoder_err_i,
  input wire logic pulser_err_i,
  input wire logic prereg_free_i,
  input wire logic accel_begin_i,
  input wire logic accel_end_i,
  input wire logic decel_begin_i,
  input wire logic decel_end_i,
  input wire logic compare_one_i,
  input wire logic compare_two_i,
  input wire logic count_latch_i,
  input wire logic latch_three_i,
  input wire logic latch_four_i,
  input wire logic motion_start_i,
  input wire logic pos_soft_det_i,
  input wire logic neg_soft_det_i,
  input wire logic origin_decel_stop_option_i,
  // pins, asynchronous
  input wire logic alarm_pin_i,
  input wire logic emergency_pin_i,
  input wire logic origin_pin_i,
  input wire logic slowdown_pin_i,
  input wire logic pos_switch_pin_i,
  input wire logic neg_switch_pin_i,
  input wire logic simultaneous_start_line_i,
  // other axes pending factors
  input wire logic other_axes_pending_i,
  output logic int_n_o,
  output logic [aifl_pkg::ERR_W-1:0] error_factor_flags_o,
  output logic [aifl_pkg::EVT_W-1:0] event_factor_flags_o
);
  // ==================================================
  // reset release
  logic rst_meta;
  logic rst_n;
  logic next_rst_meta;
  logic next_rst_n;
  // release takes two edges so no flop leaves reset on a metastable copy
  always_comb begin
    next_rst_meta = 1'b1;
    next_rst_n = rst_meta;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= next_rst_meta;
      rst_n <= next_rst_n;
    end
  end

  // ==================================================
  // pin synchronisers and edge detect
  localparam int unsigned PIN_W = 7;
  logic [PIN_W-1:0] pin_s;
  logic [PIN_W-1:0] pin_d;
  aifl_sync #(.W(PIN_W)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i({simultaneous_start_line_i, neg_switch_pin_i, pos_switch_pin_i,
          slowdown_pin_i, origin_pin_i, emergency_pin_i, alarm_pin_i}),
    .q_o(pin_s)
  );
  logic [PIN_W-1:0] next_pin_d;
  // edges ignored until synchroniser and delay stage hold real pin levels
  localparam int unsigned FILL_W = 3;
  logic [FILL_W-1:0] pin_fill;
  logic [FILL_W-1:0] next_pin_fill;
  logic pin_armed;
  logic alarm_rise;
  logic emg_rise;
  logic origin_rise;
  logic sd_rise;
  logic pos_chg;
  logic neg_chg;
  logic start_fall;
  always_comb begin
    next_pin_d = pin_s;
    next_pin_fill = {pin_fill[FILL_W-2:0], 1'b1};
    pin_armed = pin_fill[FILL_W-1];
    alarm_rise = pin_armed & pin_s[0] & ~pin_d[0];
    emg_rise = pin_armed & pin_s[1] & ~pin_d[1];
    origin_rise = pin_armed & pin_s[2] & ~pin_d[2];
    sd_rise = pin_armed & pin_s[3] & ~pin_d[3];
    pos_chg = pin_armed & (pin_s[4] ^ pin_d[4]);
    neg_chg = pin_armed & (pin_s[5] ^ pin_d[5]);
    start_fall = pin_armed & ~pin_s[6] & pin_d[6];
  end
  // a pin already active at reset release gives no event
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_d <= '0;
      pin_fill <= '0;
    end else begin
      pin_d <= next_pin_d;
      pin_fill <= next_pin_fill;
    end
  end

  // ==================================================
  // factor sources
  logic [aifl_pkg::ERR_W-1:0] err_set;
  logic [aifl_pkg::EVT_W-1:0] evt_src;
  logic [aifl_pkg::EVT_W-1:0] evt_set;
  logic [aifl_pkg::EN_W-1:0] event_enable_mask;
  // padded so the unused enable position stays inside the vector
  logic [31:0] mask_wide;
  logic cmd_emg;
  always_comb begin
    mask_wide = {14'h0000, event_enable_mask};
    cmd_emg = cmd_we_i && (cmd_code_i == aifl_pkg::CMD_EMERGENCY);
    err_set[0] = stop_pos_end_i;
    err_set[1] = stop_neg_end_i;
    err_set[2] = stop_alarm_i | (alarm_rise & axis_stopped_i);
    err_set[3] = stop_simul_i;
    err_set[aifl_pkg::ERR_EMERGENCY] = emg_rise | cmd_emg;
    err_set[5] = stop_slowdown_i;
    err_set[6] = stop_pulser_ovf_i;
    err_set[7] = encoder_err_i;
    err_set[8] = pulser_err_i;
    err_set[9] = stop_pos_soft_i;
    err_set[10] = stop_neg_soft_i;
    evt_src[0] = stop_normal_i;
    evt_src[1] = prereg_free_i;
    evt_src[2] = accel_begin_i;
    evt_src[3] = accel_end_i;
    evt_src[4] = decel_begin_i;
    evt_src[5] = decel_end_i;
    evt_src[6] = compare_one_i;
    evt_src[7] = compare_two_i;
    evt_src[8] = count_latch_i;
    evt_src[9] = origin_rise;
    evt_src[10] = sd_rise;
    evt_src[11] = pos_chg;
    evt_src[12] = neg_chg;
    evt_src[13] = start_fall;
    evt_src[14] = pos_soft_det_i;
    evt_src[15] = neg_soft_det_i;
    evt_src[16] = stop_in_decel_i & origin_decel_stop_option_i;
    evt_src[17] = motion_start_i;
    evt_src[18] = latch_three_i;
    evt_src[19] = latch_four_i;
    for (int unsigned i = 0; i < aifl_pkg::EVT_W; i++) begin
      if (aifl_pkg::aifl_en_pos(i) == aifl_pkg::NO_EN) begin
        evt_set[i] = evt_src[i];
      end else begin
        evt_set[i] = evt_src[i] & mask_wide[aifl_pkg::aifl_en_pos(i)];
      end
    end
  end

  // ==================================================
  // command decode and registers
  logic [aifl_pkg::ERR_W-1:0] err_q;
  logic [aifl_pkg::EVT_W-1:0] evt_q;
  logic [aifl_pkg::ERR_W-1:0] next_err;
  logic [aifl_pkg::EVT_W-1:0] next_evt;
  logic [aifl_pkg::EN_W-1:0] next_mask;
  logic [31:0] next_rdata;
  logic next_rvalid;
  logic [aifl_pkg::ERR_W-1:0] err_clr;
  logic [aifl_pkg::EVT_W-1:0] evt_clr;
  always_comb begin
    next_mask = event_enable_mask;
    next_rdata = buf_rdata_o;
    next_rvalid = 1'b0;
    err_clr = '0;
    evt_clr = '0;
    if (cmd_we_i) begin
      case (cmd_code_i)
        aifl_pkg::CMD_WR_MASK: begin
          next_mask = buf_wdata_i[aifl_pkg::EN_W-1:0];
        end
        aifl_pkg::CMD_CLR_ERR: begin
          if (manual_clear_i) begin
            err_clr = buf_wdata_i[aifl_pkg::ERR_W-1:0];
          end
        end
        aifl_pkg::CMD_CLR_EVT: begin
          if (manual_clear_i) begin
            evt_clr = buf_wdata_i[aifl_pkg::EVT_W-1:0];
          end
        end
        aifl_pkg::CMD_RD_ERR: begin
          next_rdata = {21'h000000, err_q};
          next_rvalid = 1'b1;
          if (!manual_clear_i) begin
            err_clr = err_q;
          end
        end
        aifl_pkg::CMD_RD_EVT: begin
          next_rdata = {12'h000, evt_q};
          next_rvalid = 1'b1;
          if (!manual_clear_i) begin
            evt_clr = evt_q;
          end
        end
        default: begin
        end
      endcase
    end
    // set beats clear in the same cycle; bits stay until cleared
    next_err = (err_q & ~err_clr) | err_set;
    next_evt = (evt_q & ~evt_clr) | evt_set;
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= '0;
      evt_q <= '0;
      event_enable_mask <= aifl_pkg::EN_RESET;
      buf_rdata_o <= 32'h00000000;
      buf_rvalid_o <= 1'b0;
    end else begin
      err_q <= next_err;
      evt_q <= next_evt;
      event_enable_mask <= next_mask;
      buf_rdata_o <= next_rdata;
      buf_rvalid_o <= next_rvalid;
    end
  end

  // ==================================================
  // interrupt request, registered, active low
  logic next_int_n;
  always_comb begin
    next_int_n = ~((|err_q) | (|evt_q) | other_axes_pending_i);
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      int_n_o <= 1'b1;
    end else begin
      int_n_o <= next_int_n;
    end
  end

  assign error_factor_flags_o = err_q;
  assign event_factor_flags_o = evt_q;
endmodule

/* File: verification/aifl_checker.sv */
`timescale 1ns/10ps
// ==========
// interrupt factor checks
module aifl_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_we_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [31:0] buf_wdata_i,
  input wire logic manual_clear_i,
  input wire logic [31:0] buf_rdata_o,
  input wire logic buf_rvalid_o,
  input wire logic stop_pos_end_i,
  input wire logic stop_alarm_i,
  input wire logic stop_simul_i,
  input wire logic other_axes_pending_i,
  input wire logic int_n_o,
  input wire logic [10:0] error_factor_flags_o,
  input wire logic [19:0] event_factor_flags_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_pos_end_set: assert property (stop_pos_end_i |=> error_factor_flags_o[0])
    else $error("end limit stop not flagged");
  a_alarm_set: assert property (stop_alarm_i |=> error_factor_flags_o[2])
    else $error("alarm stop not flagged");
  a_simul_set: assert property (stop_simul_i |=> error_factor_flags_o[3])
    else $error("simultaneous stop not flagged");
  a_emerg_cmd: assert property (cmd_we_i && cmd_code_i == 8'h05 |=> error_factor_flags_o[4])
    else $error("emergency command not flagged");
  a_err_sticky: assert property (!cmd_we_i |=>
    (error_factor_flags_o & $past(error_factor_flags_o)) == $past(error_factor_flags_o))
    else $error("error flag lost without command");
  a_err_int: assert property (|error_factor_flags_o |=> !int_n_o)
    else $error("error pending but no request");
  a_int_release: assert property (error_factor_flags_o == 11'h0 &&
    event_factor_flags_o == 20'h0 && !other_axes_pending_i |=> int_n_o)
    else $error("request held with nothing pending");
  a_err_read: assert property (cmd_we_i && cmd_code_i == 8'hf2 |=>
    buf_rvalid_o && buf_rdata_o == {21'h0, $past(error_factor_flags_o)})
    else $error("error read data wrong");
  a_manual_clear: assert property (cmd_we_i && cmd_code_i == 8'hb2 && manual_clear_i |=>
    (error_factor_flags_o & $past(buf_wdata_i[10:0])) == 11'h0)
    else $error("written one did not clear");
endmodule

/* File: verification/aifl_host.sv */
`timescale 1ns/10ps
// ==========
// host side: one command per call
module aifl_host (
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i,
  output logic cmd_we_o,
  output logic [7:0] cmd_code_o,
  output logic [31:0] wdata_o
);
  logic [31:0] rd;
  initial begin
    cmd_we_o = 1'b0;
    cmd_code_o = 8'h00;
    wdata_o = 32'h0;
  end
  // released code and data inverted so nothing stale looks valid
  task automatic cmd(input logic [7:0] c, input logic [31:0] d);
    rd = 32'hffffffff;
    @(posedge clk_i);
    #1;
    cmd_we_o = 1'b1;
    cmd_code_o = c;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    cmd_we_o = 1'b0;
    cmd_code_o = ~c;
    wdata_o = ~d;
    if (rvalid_i === 1'b1) begin
      rd = rdata_i;
    end
  endtask
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
// ==========
// bench
module testbench;
  logic clk, rst_n, man, stopped, opt, other, we, rv, int_n;
  logic [10:0] cz, err;
  logic [19:0] ce, evt;
  logic [6:0] pn;
  logic [7:0] code;
  logic [31:0] wd, rdata;
  int n_fail = 0, checks = 0, cyc = 0, m;
  aifl_top i_aifl_top (.clk_i(clk), .rst_n_i(rst_n), .cmd_we_i(we), .cmd_code_i(code),
    .buf_wdata_i(wd), .manual_clear_i(man), .buf_rdata_o(rdata), .buf_rvalid_o(rv),
    .stop_pos_end_i(cz[0]), .stop_neg_end_i(cz[1]), .stop_alarm_i(cz[2]),
    .stop_simul_i(cz[3]), .stop_slowdown_i(cz[5]), .stop_pulser_ovf_i(cz[6]),
    .stop_pos_soft_i(cz[9]), .stop_neg_soft_i(cz[10]), .stop_normal_i(ce[0]),
    .stop_in_decel_i(ce[16]), .axis_stopped_i(stopped), .encoder_err_i(cz[7]),
    .pulser_err_i(cz[8]), .prereg_free_i(ce[1]), .accel_begin_i(ce[2]),
    .accel_end_i(ce[3]), .decel_begin_i(ce[4]), .decel_end_i(ce[5]),
    .compare_one_i(ce[6]), .compare_two_i(ce[7]), .count_latch_i(ce[8]),
    .latch_three_i(ce[18]), .latch_four_i(ce[19]), .motion_start_i(ce[17]),
    .pos_soft_det_i(ce[14]), .neg_soft_det_i(ce[15]), .origin_decel_stop_option_i(opt),
    .alarm_pin_i(pn[0]), .emergency_pin_i(pn[1]), .origin_pin_i(pn[2]),
    .slowdown_pin_i(pn[3]), .pos_switch_pin_i(pn[4]), .neg_switch_pin_i(pn[5]),
    .simultaneous_start_line_i(pn[6]), .other_axes_pending_i(other), .int_n_o(int_n),
    .error_factor_flags_o(err), .event_factor_flags_o(evt));
  aifl_host i_aifl_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rv), .cmd_we_o(we),
    .cmd_code_o(code), .wdata_o(wd));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic end_of_test;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test;
    end
  end
  // events 9..13 toggle pins 2..6: rise, rise, change, change, fall of the start line
  task automatic fire(input int j, input bit e);
    @(posedge clk);
    #1;
    if (e) cz[j] = 1'b1;
    else if (j >= 9 && j <= 13) pn[j-7] = ~pn[j-7];
    else ce[j] = 1'b1;
    @(posedge clk);
    #1;
    cz = '0;
    ce = '0;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [19:0] e);
    i_aifl_host.cmd(c, 32'h0);
    `CHK(i_aifl_host.rd, {12'h000, e})
  endtask
  initial begin
    {rst_n, man, stopped, opt, other} = 5'h00;
    cz = '0;
    ce = '0;
    pn = 7'h40;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK({err, evt, int_n}, 32'h1)
    for (int b = 0; b < 11; b++) begin
      if (b == 4) i_aifl_host.cmd(8'h05, 32'h0);
      else fire(b, 1'b1);
      @(posedge clk);
      #1;
      `CHK(int_n, 1'b0)
      rd_chk(8'hf2, 20'h1 << b);
      `CHK(err, 11'h0)
    end
    stopped = 1'b1;
    pn[1:0] = 2'h3;
    repeat (5) @(posedge clk);
    rd_chk(8'hf2, 20'h14);
    for (int j = 0; j < 20; j++) fire(j, 1'b0);
    rd_chk(8'hf3, 20'h0c000);
    pn = 7'h40;
    repeat (5) @(posedge clk);
    #1;
    opt = 1'b1;
    // only the mapped enable bit is set, so a wrong mapping drops the event
    for (int j = 0; j < 20; j++) begin
      m = j < 11 ? j : j < 13 ? 11 : j == 13 ? 12 : j == 16 ? 13 : j == 17 ? 14 : j - 2;
      i_aifl_host.cmd(8'hac, (j == 14 || j == 15) ? 32'h0 : 32'h1 << m);
      fire(j, 1'b0);
      `CHK(int_n, 1'b0)
      rd_chk(8'hf3, 20'h1 << j);
    end
    man = 1'b1;
    fire(0, 1'b1);
    fire(0, 1'b1);
    fire(1, 1'b1);
    rd_chk(8'hf2, 20'h3);
    i_aifl_host.cmd(8'hb2, 32'h1);
    `CHK(err, 11'h2)
    i_aifl_host.cmd(8'hb2, 32'h2);
    other = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK({err, int_n}, 12'h000)
    other = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK(int_n, 1'b1)
    fire(19, 1'b0);
    i_aifl_host.cmd(8'hb3, 32'h80000);
    `CHK(evt, 20'h0)
    man = 1'b0;
    fire(0, 1'b1);
    i_aifl_host.cmd(8'hb2, 32'h1);
    `CHK(err, 11'h1)
    // mid-run reset drops every pending factor and the request
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    `CHK({err, evt, int_n}, 32'h1)
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    i_aifl_host.cmd(8'h05, 32'h0);
    `CHK(err, 11'h10)
    end_of_test;
  end
endmodule
bind aifl_top aifl_checker i_aifl_checker (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .cmd_we_i(cmd_we_i),
  .cmd_code_i(cmd_code_i),
  .buf_wdata_i(buf_wdata_i),
  .manual_clear_i(manual_clear_i),
  .buf_rdata_o(buf_rdata_o),
  .buf_rvalid_o(buf_rvalid_o),
  .stop_pos_end_i(stop_pos_end_i),
  .stop_alarm_i(stop_alarm_i),
  .stop_simul_i(stop_simul_i),
  .other_axes_pending_i(other_axes_pending_i),
  .int_n_o(int_n_o),
  .error_factor_flags_o(error_factor_flags_o),
  .event_factor_flags_o(event_factor_flags_o)
);
